// *** rtl/epd_fifo.sv ***
// Purpose: Small synchronous FIFO for pixel bytes
// Assumes: Single clock, valid/ready on both sides
// Notes: Depth must be a power of two
`timescale 1ns/1ps
module epd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_s;

  fifo_state_s st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (st_reg.wr - st_reg.rd) != (AW+1)'(DEPTH);
  assign out_valid = st_reg.wr != st_reg.rd;
  assign out_data = mem[st_reg.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end

  // Storage has no reset; only pointers need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // epd_fifo

// *** rtl/epd_host_seq.sv ***
// Purpose: Host sequencer bringing up, refreshing and sleeping the panel controller
// Assumes: 4-wire SPI write mode, busy pin from controller, pixel bytes from user
// Notes: One start pulse runs the whole flow; pixel bytes are streamed through a FIFO
// Operation
// - After hardware reset send software reset 0x12, then wait at least 10 ms.
// - Clear both image memories with 0x46 and 0x47, each with fill byte 0xF7.
// - Configure the gate driver output with command 0x01 and its parameters.
// - Set data entry 0x11, then horizontal window 0x44 and vertical window 0x45.
// - Configure panel border with 0x3C and its parameter byte.
// - Select temperature sensing with 0x18 before loading the waveform table.
// - Load the waveform table with 0x22 then 0x20, then wait for busy low.
// - Set address counters 0x4E and 0x4F, then stream pixels after 0x24 only; 0x26 is never sent.
// - Program booster soft-start with 0x0C before driving the panel.
// - Refresh with 0x22 plus control byte, then 0x20, and wait for busy low.
// - Enter deep sleep with 0x10 before power removal.
`timescale 1ns/1ps
module epd_host_seq #(
  parameter int unsigned RESET_WAIT_CYC = epd_pkg::SW_RESET_WAIT_CYC,
  parameter int unsigned HW_RST_CYC = epd_pkg::HW_RESET_CYC,
  // Full frame by default; a shorter stream only shortens simulation
  parameter int unsigned STREAM_BYTES = 32'(epd_pkg::IMG_BYTES)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic use_ext_temp,
  input wire logic skip_otp_lut,
  output logic seq_busy,
  output logic seq_done,
  input wire logic [7:0] pix_data,
  input wire logic pix_valid,
  output logic pix_ready,
  output epd_pkg::epd_pins_s pins,
  input wire logic panel_busy
);
  import epd_pkg::*;

  // ----------------------------------------
  // Script
  // ----------------------------------------
  localparam int unsigned N_STEPS = 40;

  function automatic epd_step_s step_at(input logic [5:0] i, input logic ext_ts);
    epd_step_s s;
    s = '{op: OP_END, val: 8'h00};
    case (i)
      6'd0: s = '{OP_CMD, CMD_SW_RESET};
      6'd1: s = '{OP_WAIT_MS, 8'h00};
      6'd2: s = '{OP_CMD, CMD_FILL_RAM0};
      6'd3: s = '{OP_DATA, FILL_BYTE};
      6'd4: s = '{OP_CMD, CMD_FILL_RAM1};
      6'd5: s = '{OP_DATA, FILL_BYTE};
      6'd6: s = '{OP_WAIT_BUSY, 8'h00};
      6'd7: s = '{OP_CMD, CMD_GATE_OUT};
      6'd8: s = '{OP_DATA, 8'hDF};
      6'd9: s = '{OP_DATA, 8'h01};
      6'd10: s = '{OP_DATA, 8'h00};
      6'd11: s = '{OP_CMD, CMD_ENTRY_MODE};
      6'd12: s = '{OP_DATA, 8'h03};
      6'd13: s = '{OP_CMD, CMD_WIN_X};
      6'd14: s = '{OP_DATA, 8'h00};
      6'd15: s = '{OP_DATA, 8'h31};
      6'd16: s = '{OP_CMD, CMD_WIN_Y};
      6'd17: s = '{OP_DATA, 8'h00};
      6'd18: s = '{OP_DATA, 8'h01};
      6'd19: s = '{OP_CMD, CMD_BORDER};
      6'd20: s = '{OP_DATA, 8'h01};
      6'd21: s = '{OP_CMD, CMD_TEMP_SENSE};
      6'd22: s = '{OP_DATA, ext_ts ? 8'h48 : 8'h80};
      6'd23: s = '{OP_SKIP_LUT, 8'h00};
      6'd24: s = '{OP_CMD, CMD_UPDATE_CTRL};
      6'd25: s = '{OP_DATA, 8'hB1};
      6'd26: s = '{OP_CMD, CMD_ACTIVATE};
      6'd27: s = '{OP_WAIT_BUSY, 8'h00};
      6'd28: s = '{OP_CMD, CMD_ADDR_X};
      6'd29: s = '{OP_DATA, 8'h00};
      6'd30: s = '{OP_CMD, CMD_ADDR_Y};
      6'd31: s = '{OP_DATA, 8'h00};
      6'd32: s = '{OP_CMD, CMD_WRITE_RAM0};
      6'd33: s = '{OP_STREAM, 8'h00};
      6'd34: s = '{OP_CMD, CMD_SOFT_START};
      6'd35: s = '{OP_DATA, 8'hAE};
      6'd36: s = '{OP_CMD, CMD_UPDATE_CTRL};
      6'd37: s = '{OP_DATA, 8'hF7};
      6'd38: s = '{OP_CMD, CMD_ACTIVATE};
      6'd39: s = '{OP_WAIT_BUSY, 8'h00};
      6'd40: s = '{OP_CMD, CMD_DEEP_SLEEP};
      6'd41: s = '{OP_DATA, 8'h01};
      default: s = '{OP_END, 8'h00};
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    epd_state_e st;
    logic [5:0] pc;
    logic [7:0] shreg;
    logic [3:0] bitn;
    logic [1:0] half;
    logic [23:0] wait_cnt;
    logic [16:0] byte_cnt;
    logic in_stream;
    logic [2:0] busy_sync;
    logic busy_clean;
    logic done;
    epd_pins_s pins;
  } seq_state_s;

  seq_state_s s_reg, s_next;
  epd_step_s cur;
  logic [7:0] f_data;
  logic f_valid, f_ready;

  // Pixel bytes pass a FIFO so the source may stall against SPI pacing
  epd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(pix_data),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  assign cur = step_at(s_reg.pc, use_ext_temp);
  assign f_ready = (s_reg.st == ST_STREAM) && (s_reg.byte_cnt != '0);
  assign pins = s_reg.pins;
  assign seq_busy = s_reg.st != ST_IDLE;
  assign seq_done = s_reg.done;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    // Only the second and third stages are compared; first stage is sync only
    s_next.busy_sync = {s_reg.busy_sync[1:0], panel_busy};
    if (s_reg.busy_sync[2] == s_reg.busy_sync[1]) begin
      s_next.busy_clean = s_reg.busy_sync[2];
    end
    case (s_reg.st)
      ST_IDLE: begin
        if (start) begin
          s_next.st = ST_HW_RST;
          s_next.pins.rst_n = 1'b0;
          s_next.wait_cnt = 24'(HW_RST_CYC);
          s_next.pc = '0;
        end
      end
      ST_HW_RST: begin
        if (s_reg.wait_cnt == 24'd0) begin
          s_next.pins.rst_n = 1'b1;
          s_next.st = ST_WAIT;
          s_next.wait_cnt = 24'(HW_RST_CYC);
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt - 24'd1;
        end
      end
      ST_FETCH: begin
        s_next.pc = s_reg.pc + 6'd1;
        case (cur.op)
          OP_CMD, OP_DATA: begin
            s_next.shreg = cur.val;
            s_next.pins.mosi = cur.val[7];
            s_next.pins.dc = cur.op == OP_DATA;
            s_next.pins.cs_n = 1'b0;
            s_next.bitn = 4'd8;
            s_next.half = 2'(SCL_HALF_CYC - 1);
            s_next.st = ST_SEND;
          end
          OP_WAIT_MS: begin
            s_next.wait_cnt = 24'(RESET_WAIT_CYC);
            s_next.st = ST_WAIT;
          end
          OP_WAIT_BUSY: begin
            // Allow the sync chain to see busy rise before testing it
            s_next.wait_cnt = 24'd4;
            s_next.st = ST_BUSY;
          end
          OP_SKIP_LUT: begin
            if (skip_otp_lut) begin
              s_next.pc = s_reg.pc + 6'd5;
            end
          end
          OP_STREAM: begin
            s_next.byte_cnt = 17'(STREAM_BYTES);
            s_next.in_stream = 1'b1;
            s_next.st = ST_STREAM;
          end
          default: begin
            s_next.st = ST_DONE;
          end
        endcase
      end
      ST_SEND: begin
        if (s_reg.half != 2'd0) begin
          s_next.half = s_reg.half - 2'd1;
        end else if (!s_reg.pins.sclk && s_reg.bitn == 4'd0) begin
          s_next.pins.cs_n = 1'b1;
          s_next.wait_cnt = 24'(CS_HIGH_CYC);
          s_next.st = ST_GAP;
        end else begin
          s_next.half = 2'(SCL_HALF_CYC - 1);
          if (!s_reg.pins.sclk) begin
            s_next.pins.sclk = 1'b1;
          end else begin
            s_next.pins.sclk = 1'b0;
            s_next.shreg = {s_reg.shreg[6:0], 1'b0};
            s_next.bitn = s_reg.bitn - 4'd1;
            // Next bit moves on the fall, a whole low phase of setup before the rise
            s_next.pins.mosi = s_reg.shreg[6];
          end
        end
      end
      ST_GAP: begin
        if (s_reg.wait_cnt == 24'd0) begin
          s_next.st = s_reg.in_stream ? ST_STREAM : ST_FETCH;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt - 24'd1;
        end
      end
      ST_WAIT: begin
        if (s_reg.wait_cnt == 24'd0) begin
          s_next.st = ST_FETCH;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt - 24'd1;
        end
      end
      ST_BUSY: begin
        if (s_reg.wait_cnt != 24'd0) begin
          s_next.wait_cnt = s_reg.wait_cnt - 24'd1;
        end else if (!s_reg.busy_clean) begin
          s_next.st = ST_FETCH;
        end
      end
      ST_STREAM: begin
        if (s_reg.byte_cnt == '0) begin
          s_next.in_stream = 1'b0;
          s_next.st = ST_FETCH;
        end else if (f_valid) begin
          s_next.byte_cnt = s_reg.byte_cnt - 17'd1;
          s_next.shreg = f_data;
          s_next.pins.mosi = f_data[7];
          s_next.pins.dc = 1'b1;
          s_next.pins.cs_n = 1'b0;
          s_next.bitn = 4'd8;
          s_next.half = 2'(SCL_HALF_CYC - 1);
          s_next.st = ST_SEND;
        end
      end
      ST_DONE: begin
        s_next.done = 1'b1;
        s_next.st = ST_IDLE;
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{st: ST_IDLE, pc: 6'd0, shreg: 8'h00, bitn: 4'd0, half: 2'd0,
                 wait_cnt: 24'd0, byte_cnt: 17'd0, in_stream: 1'b0,
                 busy_sync: 3'b000, busy_clean: 1'b0, done: 1'b0,
                 pins: '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1, dc: 1'b0, rst_n: 1'b1}};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // epd_host_seq

// *** rtl/epd_pkg.sv ***
// Purpose: Shared constants and types for the panel bring-up host sequencer
// Assumes: 40 MHz system clock, SPI write mode, 4-wire with data/command pin
// Notes: Command codes and fill values are fixed by the panel controller
package epd_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SW_RESET_WAIT_MS = 10;
  localparam int unsigned SW_RESET_WAIT_CYC = (CLK_HZ / 1000) * SW_RESET_WAIT_MS;
  localparam int unsigned HW_RESET_US = 10;
  localparam int unsigned HW_RESET_CYC = (CLK_HZ / 1_000_000) * HW_RESET_US;
  // SPI half period 50 ns (2 cycles) gives 10 MHz, inside the 20 MHz limit
  localparam int unsigned SCL_HALF_NS = 50;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS * 40 + 999) / 1000;
  // Chip select high gap between bytes, least 100 ns
  localparam int unsigned CS_HIGH_NS = 100;
  localparam int unsigned CS_HIGH_CYC = (CS_HIGH_NS * 40 + 999) / 1000;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_GATE_OUT = 8'h01;
  localparam logic [7:0] CMD_SOFT_START = 8'h0C;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'h10;
  localparam logic [7:0] CMD_ENTRY_MODE = 8'h11;
  localparam logic [7:0] CMD_SW_RESET = 8'h12;
  localparam logic [7:0] CMD_TEMP_SENSE = 8'h18;
  localparam logic [7:0] CMD_ACTIVATE = 8'h20;
  localparam logic [7:0] CMD_UPDATE_CTRL = 8'h22;
  localparam logic [7:0] CMD_WRITE_RAM0 = 8'h24;
  localparam logic [7:0] CMD_WRITE_RAM1 = 8'h26;
  localparam logic [7:0] CMD_BORDER = 8'h3C;
  localparam logic [7:0] CMD_WIN_X = 8'h44;
  localparam logic [7:0] CMD_WIN_Y = 8'h45;
  localparam logic [7:0] CMD_FILL_RAM0 = 8'h46;
  localparam logic [7:0] CMD_FILL_RAM1 = 8'h47;
  localparam logic [7:0] CMD_ADDR_X = 8'h4E;
  localparam logic [7:0] CMD_ADDR_Y = 8'h4F;
  localparam logic [7:0] FILL_BYTE = 8'hF7;

  // ----------------------------------------
  // Script and stream sizes
  // ----------------------------------------
  localparam int unsigned ROM_W = 10;
  localparam int unsigned BYTE_CNT_W = 17;
  localparam logic [16:0] IMG_BYTES = 17'h0_BB80;  // 800x480 / 8
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 16;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_HW_RST = 4'h1,
    ST_FETCH = 4'h2,
    ST_SEND = 4'h3,
    ST_GAP = 4'h4,
    ST_WAIT = 4'h5,
    ST_BUSY = 4'h6,
    ST_STREAM = 4'h7,
    ST_DONE = 4'h8
  } epd_state_e;

  // Script entry kinds
  typedef enum logic [2:0] {
    OP_CMD = 3'h0,
    OP_DATA = 3'h1,
    OP_WAIT_MS = 3'h2,
    OP_WAIT_BUSY = 3'h3,
    OP_STREAM = 3'h4,
    OP_END = 3'h5,
    OP_SKIP_LUT = 3'h6
  } epd_op_e;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
    logic dc;
    logic rst_n;
  } epd_pins_s;

  typedef struct packed {
    epd_op_e op;
    logic [7:0] val;
  } epd_step_s;

endpackage

// *** verif/epd_host_seq_assertions.sv ***
// Purpose: Port-level checks on the panel host sequencer
// Assumes: Bound to epd_host_seq, one clock domain
// Notes: Three-flop busy sync sets the wait bounds used here
`timescale 1ns/1ps
module epd_host_seq_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic seq_busy,
  input wire logic seq_done,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire epd_pkg::epd_pins_s pins,
  input wire logic panel_busy
);
  import epd_pkg::*;
  logic sclk_d_reg;
  logic [3:0] rise_cnt_reg;
  // Counts clock rises inside one chip-select frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_reg <= 1'b0;
      rise_cnt_reg <= 4'h0;
    end else begin
      sclk_d_reg <= pins.sclk;
      rise_cnt_reg <= pins.cs_n ? 4'h0 : rise_cnt_reg + {3'h0, pins.sclk & ~sclk_d_reg};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_idle_pins: assert property (!seq_busy |-> pins.cs_n && !pins.sclk)
    else $error("Link active while idle");
  chk_start_run: assert property (start && !seq_busy |=> seq_busy)
    else $error("Start not taken in idle");
  chk_hw_reset: assert property ($rose(seq_busy) |-> ##[0:2] !pins.rst_n)
    else $error("No panel reset at flow start");
  chk_sclk_phase: assert property ($rose(pins.sclk) |=> pins.sclk ##1 !pins.sclk ##1 !pins.sclk)
    else $error("Clock phase not two cycles");
  chk_mosi_stable: assert property (pins.sclk |-> $stable(pins.mosi) && $stable(pins.dc))
    else $error("Data moved while clock high");
  chk_cs_gap: assert property ($rose(pins.cs_n) |-> pins.cs_n [*4])
    else $error("Chip select gap too short");
  chk_eight_bits: assert property ($rose(pins.cs_n) |-> rise_cnt_reg == 4'h8)
    else $error("Frame not eight bits");
  chk_busy_hold: assert property (panel_busy [*4] |-> !$fell(pins.cs_n))
    else $error("Frame started while panel busy");
  chk_busy_resume: assert property ($fell(panel_busy) |-> ##[1:100] $fell(pins.cs_n))
    else $error("No resume after busy low");
  chk_done_pulse: assert property (seq_done |-> pins.cs_n ##1 !seq_done)
    else $error("Done not a single pulse");
  cover property (seq_done);
  cover property ($rose(panel_busy));
  cover property (pix_valid && !pix_ready);
endmodule // epd_host_seq_assertions

// *** verif/epd_panel_model.sv ***
// Purpose: Behavioural panel controller facing the host sequencer
// Assumes: Write-only SPI mode 0, one byte per chip-select frame
// Notes: Table load is answered promptly, a refresh slowly
`timescale 1ns/1ps
module epd_panel_model #(
  parameter int unsigned RST_CYC = 20,
  parameter int unsigned LUT_CYC = 10,
  parameter int unsigned REF_CYC = 600
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire epd_pkg::epd_pins_s pins,
  output logic busy,
  output logic stb,
  output logic [8:0] rx,
  output logic asleep
);
  import epd_pkg::*;
  localparam logic [7:0] LUT_CTL = 8'hB1;
  logic sclk_d;
  logic [7:0] sh;
  logic [7:0] b;
  logic [7:0] last_cmd;
  logic [7:0] upd_ctl;
  logic [7:0] fill [2];
  int nbits;
  int hold;
  assign busy = (hold != 0);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n || !pins.rst_n) begin
      {sclk_d, stb, asleep, sh, last_cmd, upd_ctl} = '0;
      rx = '0;
      nbits = 0;
      hold = 0;
    end else begin
      stb <= 1'b0;
      sclk_d <= pins.sclk;
      if (hold != 0) hold <= hold - 1;
      if (pins.cs_n) nbits <= 0;
      else if (pins.sclk && !sclk_d) begin
        b = {sh[6:0], pins.mosi};
        sh <= b;
        nbits <= (nbits == 7) ? 0 : nbits + 1;
        if (nbits == 7) begin
          stb <= 1'b1;
          rx <= {pins.dc, b};
          if (!pins.dc) last_cmd <= b;
          if (!pins.dc && b == CMD_SW_RESET) hold <= RST_CYC;
          if (!pins.dc && b == CMD_ACTIVATE) hold <= (upd_ctl == LUT_CTL) ? LUT_CYC : REF_CYC;
          if (pins.dc && last_cmd == CMD_UPDATE_CTRL) upd_ctl <= b;
          if (pins.dc && (last_cmd == CMD_FILL_RAM0 || last_cmd == CMD_FILL_RAM1)) fill[last_cmd[0]] <= b;
          if (!pins.dc && b == CMD_DEEP_SLEEP) asleep <= 1'b1;
        end
      end
    end
  end
endmodule // epd_panel_model

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the panel host sequencer
// Assumes: Panel model on the pins, pixel bytes fed by the bench
// Notes: Stream length is cut by parameter so the full flow stays short
`timescale 1ns/1ps
module testbench;
  import epd_pkg::*;
  localparam int unsigned N_PIX = 40;
  logic clk = 1'b0, arst_n = 1'b0, start = 1'b0, use_ext_temp = 1'b0, skip_otp_lut = 1'b0;
  logic pix_valid = 1'b0, cs_d = 1'b1, saw_rst = 1'b0;
  logic [7:0] pix_data = 8'h00;
  logic seq_busy, seq_done, pix_ready, panel_busy, stb, asleep;
  logic [8:0] rx, e;
  epd_pins_s pins;
  int miscompares = 0, compares = 0, stream_left = 0, t12 = -1, cyc = 0, n;
  logic [8:0] expq[$];
  logic [7:0] pixq[$];
  always #12.5 clk = ~clk;
  epd_host_seq #(.RESET_WAIT_CYC(50), .HW_RST_CYC(4), .STREAM_BYTES(N_PIX))
    epd_host_seq_inst (.clk(clk),
    .arst_n(arst_n), .start(start), .use_ext_temp(use_ext_temp), .skip_otp_lut(skip_otp_lut),
    .seq_busy(seq_busy), .seq_done(seq_done), .pix_data(pix_data), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pins(pins), .panel_busy(panel_busy));
  epd_panel_model epd_panel_model_inst (.clk(clk), .arst_n(arst_n), .pins(pins),
    .busy(panel_busy), .stb(stb), .rx(rx), .asleep(asleep));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Expected bytes as {dc, byte}, built from the documented order
  task automatic load_script(input logic ext, input logic skip, input logic full);
    logic [8:0] pre [20] = '{9'h012, 9'h046, 9'h1F7, 9'h047, 9'h1F7, 9'h001, 9'h1DF, 9'h101,
      9'h100, 9'h011, 9'h103, 9'h044, 9'h100, 9'h131, 9'h045, 9'h100, 9'h101, 9'h03C, 9'h101,
      9'h018};
    logic [8:0] waveform_table [3] = '{9'h022, 9'h1B1, 9'h020};
    logic [8:0] img [5] = '{9'h04E, 9'h100, 9'h04F, 9'h100, 9'h024};
    logic [8:0] fin [7] = '{9'h00C, 9'h1AE, 9'h022, 9'h1F7, 9'h020, 9'h010, 9'h101};
    foreach (pre[i]) expq.push_back(pre[i]);
    expq.push_back(ext ? 9'h148 : 9'h180);
    if (!skip) foreach (waveform_table[i]) expq.push_back(waveform_table[i]);
    foreach (img[i]) expq.push_back(img[i]);
    if (full) foreach (fin[i]) expq.push_back(fin[i]);
  endtask
  task automatic pulse_start();
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic wait_until(input logic done_mode, input int lim);
    int w;
    w = 0;
    while (!(done_mode ? seq_done === 1'b1 : expq.size() == 0 && stream_left > 0) && w < lim) begin
      @(negedge clk);
      w++;
    end
    if (w >= lim) begin
      check(9'h000, 9'h001, "wait limit");
      tally_and_finish();
    end
  endtask
  task automatic feed(input int cnt, input logic stall);
    int w;
    for (int k = 0; k < cnt; k++) begin
      pix_data <= 8'($urandom);
      pix_valid <= 1'b1;
      w = 0;
      do begin
        @(negedge clk);
        w++;
      end while (pix_ready !== 1'b1 && w < 8000);
      if (w >= 8000) begin
        check(9'h000, 9'h001, "feed limit");
        tally_and_finish();
      end
      @(posedge clk);
      if (stall && $urandom_range(3) == 0) begin
        pix_valid <= 1'b0;
        @(posedge clk);
      end
    end
    pix_valid <= 1'b0;
  endtask
  // Monitor at the falling edge, where every port has settled
  always @(negedge clk) begin
    cyc++;
    if (pix_valid && pix_ready === 1'b1) pixq.push_back(pix_data);
    if (!pins.rst_n) saw_rst = 1'b1;
    if (cs_d && !pins.cs_n) begin
      check({8'h00, panel_busy}, 9'h000, "busy at frame");
      if (t12 >= 0) check({8'h00, (cyc - t12) >= 50}, 9'h001, "reset pause");
      t12 = -1;
    end
    cs_d = pins.cs_n;
    if (stb === 1'b1) begin
      if (stream_left > 0) begin
        check(rx, {1'b1, pixq.pop_front()}, "pixel");
        stream_left--;
      end else begin
        e = (expq.size() > 0) ? expq.pop_front() : 9'h1FF;
        check(rx, e, "command");
        if (e === 9'h012) check({8'h00, saw_rst}, 9'h001, "panel reset");
        if (e === 9'h012) t12 = cyc;
        if (e === 9'h024) stream_left = N_PIX;
      end
    end
  end
  initial begin
    void'($urandom(32'h4a2c));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    use_ext_temp <= 1'b1;
    skip_otp_lut <= 1'b1;
    load_script(1'b1, 1'b1, 1'b0);
    pulse_start();
    wait_until(1'b0, 5000);
    // Cut the run at the tail of the 0x24 frame, before the stream starts, with no pixels queued
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check({8'h00, seq_busy}, 9'h000, "busy in reset");
    check({8'h00, pins.cs_n}, 9'h001, "select in reset");
    expq.delete();
    pixq.delete();
    stream_left = 0;
    saw_rst = 1'b0;
    arst_n <= 1'b1;
    $display("test skip_table_ext_temp done");
    @(posedge clk);
    use_ext_temp <= 1'b0;
    skip_otp_lut <= 1'b0;
    n = 0;
    pix_valid <= 1'b1;
    pix_data <= 8'($urandom);
    repeat (20) begin
      @(negedge clk);
      if (pix_ready === 1'b1) n++;
      @(posedge clk);
      pix_data <= (pix_ready === 1'b1) ? 8'($urandom) : pix_data;
    end
    pix_valid <= 1'b0;
    check(n[8:0], 9'h010, "fifo depth");
    $display("test fifo_fill done");
    load_script(1'b0, 1'b0, 1'b1);
    pulse_start();
    feed(N_PIX - 16, 1'b1);
    wait_until(1'b1, 20000);
    check({8'h00, asleep}, 9'h001, "deep sleep");
    check({1'b0, epd_panel_model_inst.fill[0]}, {1'b0, FILL_BYTE}, "fill first");
    check({1'b0, epd_panel_model_inst.fill[1]}, {1'b0, FILL_BYTE}, "fill second");
    check({8'h00, expq.size() == 0 && stream_left == 0}, 9'h001, "all bytes");
    @(negedge clk);
    check({8'h00, seq_busy}, 9'h000, "idle after done");
    $display("test full_flow done");
    tally_and_finish();
  end
endmodule // testbench
bind epd_host_seq epd_host_seq_assertions epd_host_seq_assertions_inst (.clk(clk),
  .arst_n(arst_n), .start(start), .seq_busy(seq_busy), .seq_done(seq_done),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .pins(pins), .panel_busy(panel_busy));
